// File: src/tss_mode_select.sv
`timescale 1ns/1ps
module tss_mode_select
   import tss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [15:0] speed_in,
   output logic signed [15:0] current_command,
   output logic update_strobe
);
   // pclk is the PLL-derived internal clock, made outside
   logic choice_reg;
   logic [15:0] torque_command_reg;
   logic [15:0] start_current_cap_reg;
   logic [15:0] regen_current_cap_reg;
   logic [15:0] motoring_current_cap_reg;
   logic signed [15:0] speed_prop_gain_reg;
   logic signed [15:0] speed_integral_gain_reg;
   logic signed [15:0] lower_bound_reg;
   logic [3:0] fexp_reg;
   logic [2:0] ctrl_reg;
   logic signed [15:0] speed_ref_reg;
   logic signed [15:0] speed_fb_reg;
   logic signed [15:0] cmd_reg;
   logic signed [15:0] pi_reg;
   logic signed [31:0] integ_reg;
   logic signed [15:0] raw_fb_reg;
   logic signed [15:0] sel_reg;
   logic signed [15:0] ramp_reg;
   logic active_choice_reg;
   logic ramping_reg;
   logic [31:0] prdata_reg;
   logic [13:0] div_reg;
   logic tick;
   tss_state_t state_reg;
   tss_state_t state_next;
   tss_filt_if fi ();

   tss_smooth_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .fi(fi)
   );

   // apb decode, zero wait states
   logic access;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [7:0] ofs;
   assign ofs = paddr[7:0];
   assign access = psel && penable;
   assign addr_ok = (paddr[31:8] == 24'h000000) && (ofs[1:0] == 2'b00)
      && (ofs <= TSS_OFS_STATUS);
   assign wr_en = access && pwrite && addr_ok;
   // read word is loaded in the setup cycle, so it stands through access
   assign rd_en = psel && !penable && !pwrite && addr_ok;
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok; // unmapped answers an error
   assign prdata = prdata_reg;

   // write-side registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         choice_reg <= TSS_CHOICE_RST;
         torque_command_reg <= 16'h0000;
         start_current_cap_reg <= TSS_CAP_RST;
         regen_current_cap_reg <= TSS_CAP_RST;
         motoring_current_cap_reg <= TSS_CAP_RST;
         speed_prop_gain_reg <= 16'sh0000;
         speed_integral_gain_reg <= 16'sh0000;
         lower_bound_reg <= 16'sh0000;
         fexp_reg <= TSS_FEXP_RST;
         ctrl_reg <= 3'h0;
         speed_ref_reg <= 16'sh0000;
      end else if (wr_en) begin
         unique case (ofs)
            TSS_OFS_CHOICE: choice_reg <= pwdata[0];
            TSS_OFS_TORQUE: torque_command_reg <= pwdata[15:0];
            TSS_OFS_START: start_current_cap_reg <= pwdata[15:0];
            TSS_OFS_REGEN: regen_current_cap_reg <= pwdata[15:0];
            TSS_OFS_MOTOR: motoring_current_cap_reg <= pwdata[15:0];
            TSS_OFS_KP: speed_prop_gain_reg <= pwdata[15:0];
            TSS_OFS_KI: speed_integral_gain_reg <= pwdata[15:0];
            TSS_OFS_LOWER: lower_bound_reg <= pwdata[15:0];
            TSS_OFS_FEXP: fexp_reg <= pwdata[3:0];
            TSS_OFS_CTRL: ctrl_reg <= pwdata[2:0];
            TSS_OFS_SPD_REF: speed_ref_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read mux
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (ofs)
         TSS_OFS_CHOICE: rd_val = {31'h0, choice_reg};
         TSS_OFS_TORQUE: rd_val = {16'h0, torque_command_reg};
         TSS_OFS_START: rd_val = {16'h0, start_current_cap_reg};
         TSS_OFS_REGEN: rd_val = {16'h0, regen_current_cap_reg};
         TSS_OFS_MOTOR: rd_val = {16'h0, motoring_current_cap_reg};
         TSS_OFS_KP: rd_val = {16'h0, speed_prop_gain_reg};
         TSS_OFS_KI: rd_val = {16'h0, speed_integral_gain_reg};
         TSS_OFS_LOWER: rd_val = {16'h0, lower_bound_reg};
         TSS_OFS_FEXP: rd_val = {28'h0, fexp_reg};
         TSS_OFS_CTRL: rd_val = {29'h0, ctrl_reg};
         TSS_OFS_SPD_REF: rd_val = {16'h0, speed_ref_reg};
         TSS_OFS_SPD_FB: rd_val = {16'h0, fi.filt_out};
         TSS_OFS_CMD_OUT: rd_val = {16'h0, cmd_reg};
         TSS_OFS_PI_OUT: rd_val = {16'h0, pi_reg};
         TSS_OFS_FILT_OUT: rd_val = {16'h0, fi.clamped};
         TSS_OFS_RAW_FB: rd_val = {16'h0, raw_fb_reg};
         TSS_OFS_STATUS: rd_val = {28'h0, ramping_reg, active_choice_reg,
            state_reg};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // read data loaded at the setup edge, valid while pready is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_reg <= 32'h0000_0000;
      else if (rd_en) prdata_reg <= rd_val;
   end

   // control-loop update divider; one-cycle enable
   assign tick = ctrl_reg[TSS_CTRL_RUN_BIT]
      && (div_reg == 14'(TSS_UPDATE_CYC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_reg <= 14'h0000;
      else if (!ctrl_reg[TSS_CTRL_RUN_BIT] || tick) div_reg <= 14'h0000;
      else div_reg <= div_reg + 14'h0001;
   end

   // update sequence: idle, pi, select, limit
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         TSS_ST_IDLE: if (tick) state_next = TSS_ST_PI;
         TSS_ST_PI: state_next = TSS_ST_SEL;
         TSS_ST_SEL: state_next = TSS_ST_LIM;
         TSS_ST_LIM: state_next = TSS_ST_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_reg <= TSS_ST_IDLE;
      else state_reg <= state_next;
   end

   // filter step with the raw speed sample
   assign fi.step = tick;
   assign fi.fexp = fexp_reg;
   assign fi.raw_in = speed_in;

   // speed PI; zero gains hold the integrator, so out is its held value shifted right by 8 (zero from reset)
   logic signed [16:0] err;
   logic signed [31:0] p_term;
   logic signed [31:0] i_add;
   logic signed [31:0] integ_next;
   logic signed [31:0] pi_sum;
   logic signed [15:0] pi_sat;
   assign err = 17'(speed_ref_reg) - 17'(fi.filt_out);
   assign p_term = 32'(err) * 32'(speed_prop_gain_reg);
   assign i_add = 32'(err) * 32'(speed_integral_gain_reg);
   assign integ_next = integ_reg + (i_add >>> 8);
   assign pi_sum = (p_term >>> 8) + (integ_next >>> 8);
   assign pi_sat = (pi_sum > 32'sd32767) ? 16'sh7FFF :
      (pi_sum < -32'sd32768) ? 16'sh8000 : 16'(pi_sum);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pi_reg <= 16'sh0000;
         integ_reg <= 32'sh0000_0000;
         raw_fb_reg <= 16'sh0000;
      end else if (state_reg == TSS_ST_PI) begin
         integ_reg <= integ_next;
         pi_reg <= pi_sat;
         raw_fb_reg <= speed_in;
      end
   end

   // mode latched once per update, no mid-update mix
   logic mode_change;
   logic signed [15:0] src;
   logic signed [15:0] ramp_next;
   logic signed [16:0] ramp_up;
   logic signed [16:0] ramp_dn;
   assign mode_change = (state_reg == TSS_ST_SEL)
      && (choice_reg != active_choice_reg);
   assign src = (choice_reg == TSS_CHOICE_TORQUE)
      ? $signed(torque_command_reg) : pi_reg;
   // signed and one bit wider, so negative commands compare right
   assign ramp_up = 17'(ramp_reg) + 17'($signed(TSS_RAMP_STEP));
   assign ramp_dn = 17'(ramp_reg) - 17'($signed(TSS_RAMP_STEP));
   assign ramp_next = (17'(src) > ramp_up) ? 16'(ramp_up)
      : (17'(src) < ramp_dn) ? 16'(ramp_dn) : src;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_choice_reg <= TSS_CHOICE_RST;
         ramping_reg <= 1'b0;
         ramp_reg <= 16'sh0000;
         sel_reg <= 16'sh0000;
      end else if (state_reg == TSS_ST_SEL) begin
         active_choice_reg <= choice_reg;
         if (mode_change && ctrl_reg[TSS_CTRL_RAMP_BIT]) begin
            ramping_reg <= 1'b1;
            ramp_reg <= pi_reg;
            sel_reg <= pi_reg;
         end else if (ramping_reg) begin
            ramp_reg <= ramp_next;
            sel_reg <= ramp_next;
            ramping_reg <= (ramp_next != src);
         end else begin
            sel_reg <= src;
         end
      end
   end

   // limiter: high cap always applied, regen cap only while lower bound is zero; no speed limit in torque mode
   logic signed [15:0] hi_cap;
   logic signed [15:0] lo_cap;
   logic signed [15:0] lim_out;
   assign hi_cap = ctrl_reg[TSS_CTRL_START_BIT]
      ? $signed(start_current_cap_reg)
      : $signed(motoring_current_cap_reg);
   assign lo_cap = (lower_bound_reg != 16'sh0000) ? lower_bound_reg
      : -$signed(regen_current_cap_reg);
   assign lim_out = (sel_reg > hi_cap) ? hi_cap :
      (sel_reg < lo_cap) ? lo_cap : sel_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cmd_reg <= 16'sh0000;
      else if (state_reg == TSS_ST_LIM) cmd_reg <= lim_out;
   end

   assign current_command = cmd_reg;
   assign update_strobe = (state_reg == TSS_ST_LIM);
endmodule

// File: src/tss_pkg.sv
package tss_pkg;
   // register byte offsets
   localparam logic [7:0] TSS_OFS_CHOICE = 8'h00;
   localparam logic [7:0] TSS_OFS_TORQUE = 8'h04;
   localparam logic [7:0] TSS_OFS_START = 8'h08;
   localparam logic [7:0] TSS_OFS_REGEN = 8'h0C;
   localparam logic [7:0] TSS_OFS_MOTOR = 8'h10;
   localparam logic [7:0] TSS_OFS_KP = 8'h14;
   localparam logic [7:0] TSS_OFS_KI = 8'h18;
   localparam logic [7:0] TSS_OFS_LOWER = 8'h1C;
   localparam logic [7:0] TSS_OFS_FEXP = 8'h20;
   localparam logic [7:0] TSS_OFS_CTRL = 8'h24;
   localparam logic [7:0] TSS_OFS_SPD_REF = 8'h28;
   localparam logic [7:0] TSS_OFS_SPD_FB = 8'h2C;
   localparam logic [7:0] TSS_OFS_CMD_OUT = 8'h30;
   localparam logic [7:0] TSS_OFS_PI_OUT = 8'h34;
   localparam logic [7:0] TSS_OFS_FILT_OUT = 8'h38;
   localparam logic [7:0] TSS_OFS_RAW_FB = 8'h3C;
   localparam logic [7:0] TSS_OFS_STATUS = 8'h40;
   // field positions and values
   localparam int TSS_CTRL_RUN_BIT = 0;
   localparam int TSS_CTRL_START_BIT = 1;
   localparam int TSS_CTRL_RAMP_BIT = 2;
   localparam logic TSS_CHOICE_TORQUE = 1'b0;
   localparam logic TSS_CHOICE_SPEED = 1'b1;
   // reset values, rated current and ramp step
   localparam logic TSS_CHOICE_RST = 1'b1;
   localparam logic [15:0] TSS_RATED_CURRENT = 16'h0FFF;
   localparam logic [15:0] TSS_CAP_RST = 16'h0FFF;
   localparam logic [3:0] TSS_FEXP_RST = 4'hF;
   localparam logic [15:0] TSS_RAMP_STEP = 16'h0010;
   // timing: control update every 100 us at 100 MHz
   localparam int TSS_CLK_MHZ = 100;
   localparam int TSS_UPDATE_US = 100;
   localparam int TSS_UPDATE_CYC = TSS_UPDATE_US * TSS_CLK_MHZ;
   localparam logic [31:0] TSS_BAD_ADDR = 32'h0000_0000;
   typedef enum logic [1:0] {
      TSS_ST_IDLE = 2'b00,
      TSS_ST_PI = 2'b01,
      TSS_ST_SEL = 2'b10,
      TSS_ST_LIM = 2'b11
   } tss_state_t;
endpackage

// File: src/tss_filt_if.sv
`timescale 1ns/1ps
interface tss_filt_if;
   logic step;
   logic [3:0] fexp;
   logic signed [15:0] raw_in;
   logic signed [15:0] clamped;
   logic signed [15:0] filt_out;
   modport ctl (output step, output fexp, output raw_in,
      input clamped, input filt_out);
   modport flt (input step, input fexp, input raw_in,
      output clamped, output filt_out);
endinterface

// File: src/tss_smooth_filter.sv
`timescale 1ns/1ps
module tss_smooth_filter
   import tss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   tss_filt_if.flt fi
);
   logic signed [15:0] prev_reg;
   logic signed [15:0] clamp_reg;
   logic signed [15:0] acc_reg;
   logic signed [16:0] diff;
   logic signed [16:0] lim;
   logic signed [15:0] clamp_next;
   logic signed [16:0] acc_delta;
   // step from previous clamped sample, capped at two to the exponent
   assign diff = 17'(fi.raw_in) - 17'(prev_reg);
   assign lim = 17'(17'sd1 <<< fi.fexp);
   assign clamp_next = (diff > lim) ? 16'(17'(prev_reg) + lim) :
      (diff < -lim) ? 16'(17'(prev_reg) - lim) : fi.raw_in;
   // first-order smoothing, shift of 3
   assign acc_delta = (17'(clamp_reg) - 17'(acc_reg)) >>> 3;
   // the clamp sits only on this filter path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= 16'sh0000;
         clamp_reg <= 16'sh0000;
         acc_reg <= 16'sh0000;
      end else if (fi.step) begin
         prev_reg <= clamp_next;
         clamp_reg <= clamp_next;
         acc_reg <= 16'(17'(acc_reg) + acc_delta);
      end
   end
   assign fi.clamped = clamp_reg;
   assign fi.filt_out = acc_reg;
endmodule

// File: test/tss_mode_select_asserts.sv
`timescale 1ns/1ps
module tss_mode_select_asserts
   import tss_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic signed [15:0] speed_in,
   input wire logic signed [15:0] current_command,
   input wire logic update_strobe
);
   logic [15:0] gap_reg;
   logic seen_reg;
   wire logic acc = psel && penable;
   // cycles since the last load; the first load has no reference point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end else begin
         gap_reg <= update_strobe ? 16'h0000 : gap_reg + 16'h0001;
         seen_reg <= seen_reg | update_strobe;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_hold; !update_strobe |=> $stable(current_command); endproperty
   a_hold: assert property (p_hold)
      else $error("command moved outside an update");
   property p_range;
      current_command <= 16'sh0FFF && current_command >= 16'shF001;
   endproperty
   a_range: assert property (p_range)
      else $error("command beyond the current caps");
   property p_gap; update_strobe && seen_reg |-> gap_reg >= 16'h270F; endproperty
   a_gap: assert property (p_gap)
      else $error("updates closer than the loop period");
   property p_pulse; update_strobe |=> !update_strobe; endproperty
   a_pulse: assert property (p_pulse)
      else $error("update strobe longer than one cycle");
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready)
      else $error("access phase without ready");
   property p_err_map; acc && paddr > 32'h0000_0040 |-> pslverr; endproperty
   a_err_map: assert property (p_err_map)
      else $error("unmapped access not refused");
   property p_err_ok;
      acc && paddr <= 32'h0000_0040 && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_err_ok: assert property (p_err_ok)
      else $error("mapped access refused");
   property p_err_idle; !acc |-> !pslverr; endproperty
   a_err_idle: assert property (p_err_idle)
      else $error("error outside an access phase");
   property p_rd_hold;
      !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");
   c_update: cover property (update_strobe);
   c_refused: cover property (acc && pslverr);
   c_capped: cover property (current_command == 16'sh0FFF);
endmodule

// File: test/tss_mode_select_test.sv
`timescale 1ns/1ps
module tss_mode_select_test
   import tss_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic signed [15:0] speed_in = 16'sh0000;
   logic signed [15:0] current_command;
   logic update_strobe;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int comparisons = 0;
   tss_mode_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .speed_in(speed_in), .current_command(current_command),
      .update_strobe(update_strobe));
   task automatic end_of_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h000000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         end_of_test();
      end
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // returns one edge after the edge that loads the command
   task automatic wait_upd();
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (update_strobe !== 1'b1 && n < 12000);
      if (n >= 12000) begin
         miscompares++;
         end_of_test();
      end
      @(posedge pclk);
   endtask
   task automatic t_reset();
      apb(1'b0, TSS_OFS_CHOICE, 32'h0);
      chk(rd, {31'h0, TSS_CHOICE_RST});
      apb(1'b0, TSS_OFS_MOTOR, 32'h0);
      chk(rd, {16'h0000, TSS_CAP_RST});
      apb(1'b0, TSS_OFS_FEXP, 32'h0);
      chk(rd, 32'h0000_000F);
      apb(1'b1, 8'h44, 32'h0000_0001);
      chk({31'h0, err}, 32'h0000_0001);
   endtask
   // large feedback must not bend the torque command
   task automatic t_torque();
      speed_in <= 16'sh1B58;
      apb(1'b1, TSS_OFS_KP, 32'h0);
      apb(1'b1, TSS_OFS_KI, 32'h0);
      apb(1'b1, TSS_OFS_CHOICE, {31'h0, TSS_CHOICE_TORQUE});
      apb(1'b1, TSS_OFS_TORQUE, 32'h0000_0064);
      apb(1'b1, TSS_OFS_CTRL, 32'h0000_0001);
      wait_upd();
      chk({16'h0000, current_command}, 32'h0000_0064);
      apb(1'b1, TSS_OFS_TORQUE, 32'h0000_1388);
      wait_upd();
      chk({16'h0000, current_command}, {16'h0000, TSS_RATED_CURRENT});
      apb(1'b1, TSS_OFS_START, 32'h0000_0032);
      apb(1'b1, TSS_OFS_CTRL, 32'h0000_0003);
      wait_upd();
      chk({16'h0000, current_command}, 32'h0000_0032);
      apb(1'b1, TSS_OFS_CTRL, 32'h0000_0001);
   endtask
   task automatic t_speed();
      apb(1'b1, TSS_OFS_SPD_REF, 32'h0000_03E8);
      apb(1'b1, TSS_OFS_CHOICE, {31'h0, TSS_CHOICE_SPEED});
      wait_upd();
      chk({16'h0000, current_command}, 32'h0);
      apb(1'b0, TSS_OFS_PI_OUT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, TSS_OFS_LOWER, 32'h0000_00C8);
      wait_upd();
      chk({16'h0000, current_command}, 32'h0000_00C8);
   endtask
   task automatic t_filter();
      speed_in <= 16'sh1F40;
      apb(1'b1, TSS_OFS_FEXP, 32'h0000_0008);
      wait_upd();
      apb(1'b0, TSS_OFS_FILT_OUT, 32'h0);
      chk(rd, 32'h0000_1C58);
      apb(1'b0, TSS_OFS_RAW_FB, 32'h0);
      chk(rd, 32'h0000_1F40);
      apb(1'b1, TSS_OFS_FEXP, 32'h0);
      wait_upd();
      apb(1'b0, TSS_OFS_FILT_OUT, 32'h0);
      chk(rd, 32'h0000_1C59);
   endtask
   // switch to torque with ramp on: starts at pi output, then steps
   task automatic t_ramp();
      apb(1'b1, TSS_OFS_LOWER, 32'h0);
      apb(1'b1, TSS_OFS_TORQUE, 32'h0000_0030);
      apb(1'b1, TSS_OFS_CTRL, 32'h0000_0005);
      apb(1'b1, TSS_OFS_CHOICE, {31'h0, TSS_CHOICE_TORQUE});
      wait_upd();
      chk({16'h0000, current_command}, 32'h0);
      apb(1'b0, TSS_OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_0008);
      wait_upd();
      chk({16'h0000, current_command}, {16'h0000, TSS_RAMP_STEP});
   endtask
   initial begin
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_torque();
      t_speed();
      t_filter();
      t_ramp();
      end_of_test();
   end
endmodule
bind tss_mode_select tss_mode_select_asserts u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .speed_in(speed_in),
   .current_command(current_command), .update_strobe(update_strobe));
